// >>> logic/bit_pacer.sv
// Purpose: quarter-bit enable pulses for the serial engine
// Assumes: clk_sys at 40 MHz
// Notes:   counting stops while hold is high

module bit_pacer
	import sensor_link_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	pace_if.gen      pace
);

	logic [4:0] cnt_ff;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= PACE_RST;
		end else if (!pace.hold) begin
			if (cnt_ff == 5'h00) begin
				cnt_ff <= (pace.spi_sel ? SPI_QTR_CYC : I2C_QTR_CYC) - 5'h01;
			end else begin
				cnt_ff <= cnt_ff - 5'h01;
			end
		end
	end

	assign pace.tick = (cnt_ff == 5'h00) && !pace.hold;

endmodule : bit_pacer

// >>> logic/serial_port_host.sv
// Purpose: host controller for a sensor's two-wire / SPI register port
// Assumes: shared pads; cs high selects two-wire, low selects SPI
// Notes:   software sets up a transfer and writes the go register
// Operation
// - start: data falls while clock high; bus busy afterwards
// - stop: data rises while clock high; every transfer ends so
// - first byte after start: seven address bits plus direction bit
// - transmitter releases data at ack; receiver pulls low, holds
// - after address ack, index byte: low seven index, top increments
// - read: write address and index, repeated start, address read
// - master acks each read byte except the last, then stops
// - bytes of eight bits, msb first, count unlimited; host moves at most 16 data bytes per transfer
// - receiver may hold clock low; transfer waits for release
// - slave not acking its address leaves data high; master aborts
// - SPI cs low over whole transaction; clock parked high otherwise
// - SPI data change on falling clock, sampled on rising clock
// - single SPI access is 16 pulses; each extra byte adds 8
// - bit 0 at first falling edge, last bit before cs rises
// - SPI bits 2-7 are six-bit index, bits 8-15 data
// - cs tied high selects two-wire, low selects SPI
//
// Decided for this implementation: the plain strobed port and the placing of the registers.

module serial_port_host
	import sensor_link_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic [4:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       port_clock_level,
	output logic            port_clock_drive,
	output logic            port_clock_en,
	input  wire logic       data_line_level,
	output logic            data_line_drive,
	output logic            data_line_en,
	input  wire logic       serial_out_addr_select_pin,
	output logic            chip_select
);

	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic       clk_s;
	logic       dat_s;
	logic       sdo_s;
	logic       spi_mode_ff;
	logic       three_wire_ff;
	logic       read_dir_ff;
	logic       auto_inc_ff;
	logic       addr_sel_ff;
	logic [6:0] index_ff;
	logic [3:0] last_ff;
	logic [7:0] buf_ff [BUF_DEPTH];
	state_t     state_ff;
	stage_t     stage_ff;
	logic [1:0] phase_ff;
	logic [3:0] bcnt_ff;
	logic [3:0] dcnt_ff;
	logic [7:0] sh_ff;
	logic       rep_ff;
	logic       nack_ff;
	logic       done_ff;
	logic       scl_low_ff;
	logic       sda_low_ff;
	logic       spi_clk_ff;
	logic       spi_dout_ff;
	logic       spi_oe_ff;
	logic       cs_ff;
	logic [7:0] rdata_ff;
	logic [7:0] edge_cnt_ff;
	logic       go;
	logic       step;
	logic       final_byte;
	logic       rx_data;
	logic       spi_din;
	logic       cap_we;
	logic [7:0] cap_byte;

	pace_if pace ();

	bit_pacer u_pacer (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.pace    (pace.gen)
	);

	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	// -------------------------------------------------------------
	// pad synchronisers
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= PAD_IDLE;
			sync_ff <= PAD_IDLE;
		end else begin
			meta_ff <= {serial_out_addr_select_pin, data_line_level,
				port_clock_level};
			sync_ff <= meta_ff;
		end
	end

	assign {sdo_s, dat_s, clk_s} = sync_ff;

	assign go         = wr && (addr == REG_GO) && (state_ff == ST_IDLE);
	assign step       = pace.tick;
	assign final_byte = (dcnt_ff == last_ff);
	assign rx_data    = (stage_ff == STG_DATA) && read_dir_ff;
	assign spi_din    = three_wire_ff ? dat_s : sdo_s;
	assign pace.spi_sel = spi_mode_ff;
	// stretched clock freezes the bit pacing
	assign pace.hold  = !spi_mode_ff && (state_ff != ST_IDLE) &&
		!scl_low_ff && !clk_s;

	function automatic logic [7:0] load_byte(input stage_t stg,
		input logic [3:0] ptr);
		unique case (stg)
			STG_ADDR_W: load_byte = {BUS_ADDR_HI, addr_sel_ff, 1'h0};
			STG_ADDR_R: load_byte = {BUS_ADDR_HI, addr_sel_ff, 1'h1};
			STG_INDEX:  load_byte = {auto_inc_ff, index_ff};
			STG_DATA:   load_byte = read_dir_ff ? IDLE_BYTE : buf_ff[ptr];
		endcase
	endfunction : load_byte

	// -------------------------------------------------------------
	// command registers
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			spi_mode_ff   <= 1'h0;
			three_wire_ff <= 1'h0;
			read_dir_ff   <= 1'h0;
			auto_inc_ff   <= 1'h0;
			addr_sel_ff   <= 1'h0;
			index_ff      <= INDEX_RST;
			last_ff       <= COUNT_RST;
		end else if (wr && state_ff == ST_IDLE) begin
			if (addr == REG_CTRL) begin
				spi_mode_ff   <= wdata[CTRL_SPI];
				three_wire_ff <= wdata[CTRL_3W];
				read_dir_ff   <= wdata[CTRL_READ];
				auto_inc_ff   <= wdata[CTRL_INC];
				addr_sel_ff   <= wdata[CTRL_ASEL];
			end
			if (addr == REG_INDEX) begin
				index_ff <= wdata[6:0];
			end
			if (addr == REG_COUNT) begin
				last_ff <= wdata[3:0];
			end
		end
	end

	// -------------------------------------------------------------
	// data buffer
	// -------------------------------------------------------------
	assign cap_we = step && (phase_ff == 2'h3) && rx_data &&
		((state_ff == ST_BYTE && bcnt_ff == ACK_BIT) ||
		 (state_ff == ST_SPI && bcnt_ff == SPI_LAST_BIT));
	assign cap_byte = (state_ff == ST_SPI) ? {sh_ff[6:0], spi_din} : sh_ff;

	always_ff @(posedge clk_sys) begin
		if (cap_we) begin
			buf_ff[dcnt_ff] <= cap_byte;
		end else if (wr && addr[BUF_SEL_BIT] && state_ff == ST_IDLE) begin
			buf_ff[addr[3:0]] <= wdata;
		end
	end

	// -------------------------------------------------------------
	// read port
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= 8'h00;
		end else if (!rd) begin
			rdata_ff <= 8'h00;
		end else if (addr[BUF_SEL_BIT]) begin
			rdata_ff <= buf_ff[addr[3:0]];
		end else begin
			case (addr)
				REG_CTRL:   rdata_ff <= {3'h0, addr_sel_ff, auto_inc_ff,
					read_dir_ff, three_wire_ff, spi_mode_ff};
				REG_INDEX:  rdata_ff <= {1'h0, index_ff};
				REG_COUNT:  rdata_ff <= {4'h0, last_ff};
				REG_STATUS: rdata_ff <= {5'h00, done_ff, nack_ff,
					state_ff != ST_IDLE};
				default:    rdata_ff <= 8'h00;
			endcase
		end
	end

	// -------------------------------------------------------------
	// transfer sequencer
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
			stage_ff <= STG_ADDR_W;
			phase_ff <= 2'h0;
			bcnt_ff  <= 4'h0;
			dcnt_ff  <= 4'h0;
			sh_ff    <= IDLE_BYTE;
			rep_ff   <= 1'h0;
			nack_ff  <= 1'h0;
			done_ff  <= 1'h0;
		end else if (go) begin
			phase_ff <= 2'h0;
			bcnt_ff  <= 4'h0;
			dcnt_ff  <= 4'h0;
			stage_ff <= STG_ADDR_W;
			rep_ff   <= 1'h0;
			nack_ff  <= 1'h0;
			done_ff  <= 1'h0;
			if (spi_mode_ff) begin
				state_ff <= ST_SPI;
				// direction, increment, six-bit index
				sh_ff <= {read_dir_ff, auto_inc_ff, index_ff[5:0]};
			end else begin
				state_ff <= ST_START;
			end
		end else if (step) begin
			phase_ff <= phase_ff + 2'h1;
			unique case (state_ff)
				ST_START: begin
					if (phase_ff == 2'h3) begin
						state_ff <= ST_BYTE;
						bcnt_ff  <= 4'h0;
						sh_ff    <= load_byte(stage_ff, dcnt_ff);
					end
				end
				ST_BYTE: begin
					if (phase_ff == 2'h3) begin
						sh_ff   <= {sh_ff[6:0], dat_s};
						bcnt_ff <= bcnt_ff + 4'h1;
						if (bcnt_ff == ACK_BIT) begin
							bcnt_ff <= 4'h0;
							if (rx_data) begin
								if (final_byte) begin
									state_ff <= ST_STOP;
								end else begin
									dcnt_ff <= dcnt_ff + 4'h1;
									sh_ff   <= IDLE_BYTE;
								end
							end else if (dat_s) begin
								nack_ff  <= 1'h1;
								state_ff <= ST_STOP;
							end else begin
								unique case (stage_ff)
									STG_ADDR_W: begin
										stage_ff <= STG_INDEX;
										sh_ff <= load_byte(STG_INDEX, dcnt_ff);
									end
									STG_INDEX: begin
										if (read_dir_ff) begin
											stage_ff <= STG_ADDR_R;
											rep_ff   <= 1'h1;
											state_ff <= ST_START;
										end else begin
											stage_ff <= STG_DATA;
											sh_ff <= load_byte(STG_DATA, dcnt_ff);
										end
									end
									STG_ADDR_R: begin
										stage_ff <= STG_DATA;
										sh_ff    <= IDLE_BYTE;
									end
									STG_DATA: begin
										if (final_byte) begin
											state_ff <= ST_STOP;
										end else begin
											dcnt_ff <= dcnt_ff + 4'h1;
											sh_ff <= load_byte(STG_DATA,
												dcnt_ff + 4'h1);
										end
									end
								endcase
							end
						end
					end
				end
				ST_STOP: begin
					if (phase_ff == 2'h3) begin
						state_ff <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (phase_ff == 2'h3) begin
						state_ff <= ST_IDLE;
						done_ff  <= 1'h1;
					end
				end
				ST_SPI: begin
					if (phase_ff == 2'h3) begin
						sh_ff   <= {sh_ff[6:0], spi_din};
						bcnt_ff <= bcnt_ff + 4'h1;
						if (bcnt_ff == SPI_LAST_BIT) begin
							bcnt_ff <= 4'h0;
							if (stage_ff == STG_ADDR_W) begin
								stage_ff <= STG_DATA;
								sh_ff <= load_byte(STG_DATA, dcnt_ff);
							end else if (final_byte) begin
								state_ff <= ST_DONE;
							end else begin
								dcnt_ff <= dcnt_ff + 4'h1;
								sh_ff <= load_byte(STG_DATA,
									dcnt_ff + 4'h1);
							end
						end
					end
				end
				ST_IDLE: ;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// -------------------------------------------------------------
	// pad drive
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_low_ff  <= 1'h0;
			sda_low_ff  <= 1'h0;
			spi_clk_ff  <= 1'h1;
			spi_dout_ff <= 1'h1;
			spi_oe_ff   <= 1'h1;
			cs_ff       <= 1'h1;
		end else if (go) begin
			spi_oe_ff <= 1'h1;
			cs_ff     <= !spi_mode_ff;
		end else if (step) begin
			unique case (state_ff)
				ST_START: begin
					unique case (phase_ff)
						2'h0: begin
							sda_low_ff <= 1'h0;
							scl_low_ff <= rep_ff;
						end
						2'h1: scl_low_ff <= 1'h0;
						2'h2: sda_low_ff <= 1'h1;
						2'h3: scl_low_ff <= 1'h1;
					endcase
				end
				ST_BYTE: begin
					unique case (phase_ff)
						2'h0: begin
							// ack slot: pull low only for a non-final read byte
							sda_low_ff <= (bcnt_ff == ACK_BIT) ?
								(rx_data && !final_byte) : !sh_ff[7];
						end
						2'h1: scl_low_ff <= 1'h0;
						2'h2: ;
						// clock falls at sample; data moves later
						2'h3: scl_low_ff <= 1'h1;
					endcase
				end
				ST_STOP: begin
					unique case (phase_ff)
						2'h0: begin
							scl_low_ff <= 1'h1;
							sda_low_ff <= 1'h1;
						end
						2'h1: scl_low_ff <= 1'h0;
						2'h2: sda_low_ff <= 1'h0;
						2'h3: ;
					endcase
				end
				ST_SPI: begin
					unique case (phase_ff)
						2'h0: begin
							spi_clk_ff  <= 1'h0;
							spi_dout_ff <= sh_ff[7];
							// shared line handed to the device from bit 8
							spi_oe_ff <= !(three_wire_ff && rx_data);
						end
						2'h1: ;
						2'h2: spi_clk_ff <= 1'h1;
						2'h3: begin
							if (bcnt_ff == SPI_LAST_BIT &&
								stage_ff == STG_DATA && final_byte) begin
								cs_ff <= 1'h1;
							end
						end
					endcase
				end
				ST_DONE: spi_oe_ff <= 1'h1;
				ST_IDLE: ;
				default: ;
			endcase
		end
	end

	assign port_clock_drive = spi_mode_ff ? spi_clk_ff : 1'h0;
	assign port_clock_en    = spi_mode_ff ? 1'h1 : scl_low_ff;
	assign data_line_drive  = spi_mode_ff ? spi_dout_ff : 1'h0;
	assign data_line_en     = spi_mode_ff ? spi_oe_ff : sda_low_ff;
	assign chip_select      = cs_ff;
	assign rdata            = rdata_ff;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			edge_cnt_ff <= 8'h00;
		end else if (go) begin
			edge_cnt_ff <= 8'h00;
		end else if (step && state_ff == ST_SPI && phase_ff == 2'h2) begin
			edge_cnt_ff <= edge_cnt_ff + 8'h01;
		end
	end

	sequence s_start_fall;
		step && state_ff == ST_START && phase_ff == 2'h2;
	endsequence
	sequence s_stop_rise;
		step && state_ff == ST_STOP && phase_ff == 2'h2;
	endsequence

	property p_start;
		s_start_fall |=> sda_low_ff && !scl_low_ff && clk_s;
	endproperty
	a_start: assert property (p_start)
		else $error("start without clock high");

	property p_stop;
		s_stop_rise |=> !sda_low_ff && !scl_low_ff ##1 !sda_low_ff;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop condition not formed");

	property p_addr;
		(state_ff == ST_BYTE && $past(state_ff) == ST_START) |->
			sh_ff == {BUS_ADDR_HI, addr_sel_ff, stage_ff == STG_ADDR_R};
	endproperty
	a_addr: assert property (p_addr)
		else $error("wrong address byte");

	property p_index;
		($past(stage_ff) == STG_ADDR_W && stage_ff == STG_INDEX) |->
			sh_ff == {auto_inc_ff, index_ff};
	endproperty
	a_index: assert property (p_index)
		else $error("wrong index byte");

	property p_mack;
		(step && state_ff == ST_BYTE && phase_ff == 2'h0 &&
			bcnt_ff == ACK_BIT && rx_data) |=> sda_low_ff == !final_byte;
	endproperty
	a_mack: assert property (p_mack)
		else $error("master ack level wrong");

	property p_nack;
		(step && state_ff == ST_BYTE && phase_ff == 2'h3 &&
			bcnt_ff == ACK_BIT && !rx_data && dat_s) |=>
			state_ff == ST_STOP && nack_ff;
	endproperty
	a_nack: assert property (p_nack)
		else $error("missing ack not aborted");

	property p_stretch;
		pace.hold |=> phase_ff == $past(phase_ff);
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("phase moved while clock held");

	property p_park;
		cs_ff |-> spi_clk_ff;
	endproperty
	a_park: assert property (p_park)
		else $error("port clock not parked high");

	property p_mosi;
		(state_ff == ST_SPI && $changed(spi_dout_ff)) |-> !spi_clk_ff;
	endproperty
	a_mosi: assert property (p_mosi)
		else $error("data changed off falling edge");

	property p_len;
		$rose(cs_ff) |-> edge_cnt_ff == 8'((8'(last_ff) + 8'h02) << 3);
	endproperty
	a_len: assert property (p_len)
		else $error("wrong clock pulse count");

	property p_three_wire;
		(step && state_ff == ST_SPI && phase_ff == 2'h0 &&
			three_wire_ff && rx_data) |=> !spi_oe_ff;
	endproperty
	a_three_wire: assert property (p_three_wire)
		else $error("shared line not released");

	property p_cs_mode;
		!spi_mode_ff |-> cs_ff;
	endproperty
	a_cs_mode: assert property (p_cs_mode)
		else $error("cs low in two-wire mode");

endmodule : serial_port_host

// >>> shared/pace_if.sv
// Purpose: quarter-bit pacing between engine and divider
// Assumes: one clock domain
// Notes:   hold freezes the divider while the clock line is stretched

interface pace_if;
	logic tick;
	logic hold;
	logic spi_sel;
	modport gen  (output tick, input hold, input spi_sel);
	modport user (input tick, output hold, output spi_sel);
endinterface : pace_if

// >>> shared/sensor_link_pkg.sv
// Purpose: constants and types for the serial register port host
// Assumes: 40 MHz system clock, 8-bit register window
// Notes:   register offsets belong to the host's own command window

package sensor_link_pkg;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int I2C_RATE_KHZ  = 400;
	localparam int I2C_BIT_NS    = 1_000_000 / I2C_RATE_KHZ;
	localparam int SPI_BIT_NS    = 200;
	localparam int QTR_NS        = 4 * CLK_PERIOD_NS;
	localparam logic [4:0] I2C_QTR_CYC =
		5'((I2C_BIT_NS + QTR_NS - 1) / QTR_NS);
	localparam logic [4:0] SPI_QTR_CYC =
		5'((SPI_BIT_NS + QTR_NS - 1) / QTR_NS);
	localparam logic [4:0] PACE_RST = 5'h00;

	// -------------------------------------------------------------
	// host command window
	// -------------------------------------------------------------
	localparam logic [4:0] REG_CTRL    = 5'h00;
	localparam logic [4:0] REG_INDEX   = 5'h01;
	localparam logic [4:0] REG_COUNT   = 5'h02;
	localparam logic [4:0] REG_GO      = 5'h03;
	localparam logic [4:0] REG_STATUS  = 5'h04;
	localparam int         BUF_SEL_BIT = 4;
	localparam int         BUF_DEPTH   = 16;
	localparam int CTRL_SPI  = 0;
	localparam int CTRL_3W   = 1;
	localparam int CTRL_READ = 2;
	localparam int CTRL_INC  = 3;
	localparam int CTRL_ASEL = 4;
	localparam logic [6:0] INDEX_RST = 7'h00;
	localparam logic [3:0] COUNT_RST = 4'h0;

	// -------------------------------------------------------------
	// link framing
	// -------------------------------------------------------------
	localparam logic [5:0] BUS_ADDR_HI  = 6'h2e;
	localparam logic [7:0] IDLE_BYTE    = 8'hff;
	localparam logic [3:0] ACK_BIT      = 4'h8;
	localparam logic [3:0] SPI_LAST_BIT = 4'h7;
	localparam logic [2:0] PAD_IDLE     = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_START = 3'h1,
		ST_BYTE  = 3'h3,
		ST_STOP  = 3'h2,
		ST_DONE  = 3'h6,
		ST_SPI   = 3'h4
	} state_t;

	typedef enum logic [1:0] {
		STG_ADDR_W = 2'h0,
		STG_INDEX  = 2'h1,
		STG_DATA   = 2'h3,
		STG_ADDR_R = 2'h2
	} stage_t;

endpackage : sensor_link_pkg

// >>> tb/sensor_model.sv
// Purpose: behavioural sensor behind the shared serial pads
// Assumes: cs high selects two-wire, low selects SPI
// Notes:   slow stretches the clock after each two-wire written data byte
module sensor_model (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic cs,
	input  wire logic sa0,
	input  wire logic slow,
	output logic      scl_hold = 1'b0,
	output logic      sda_en = 1'b0,
	output logic      sda_val = 1'b0,
	output logic      sdo_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SIM_BIT = 0;
	localparam int FIFO_BIT = 0;
	logic [7:0] mem [0:127];
	logic [7:0] sh = 8'h00;
	logic [7:0] dout = 8'h00;
	logic [6:0] idx = 7'h00;
	logic       inc = 1'b0;
	logic       tx = 1'b0;
	logic       sel = 1'b0;
	logic       sent = 1'b0;
	logic       rw = 1'b0;
	logic       sdo = 1'b0;
	int         cnt = 0;
	int         nb = 0;
	int         bc = 0;
	int         macks = 0;
	int         nmacks = 0;
	initial foreach (mem[i]) mem[i] = 8'h00;
	assign sdo_pin = cs ? sa0 : sdo;
	// two-wire start, repeated start and stop
	always @(negedge sda) if (scl && cs) begin
		cnt = 0;
		nb = 0;
		tx = 1'b0;
		sent = 1'b0;
	end
	always @(posedge sda) if (scl && cs) sel = 1'b0;
	always @(posedge scl) if (cs) begin
		if (cnt == 8 && sent) begin
			sent = 1'b0;
			if (sda) nmacks++;
			else macks++;
			if (sda) sel = 1'b0;
		end
		if (cnt < 8) sh = {sh[6:0], sda};
		cnt = (cnt == 8) ? 0 : cnt + 1;
	end
	always @(negedge scl) if (cs) begin
		sda_en = 1'b0;
		if (cnt == 8 && !tx) begin
			if (nb == 0) sel = (sh[7:1] == {6'h2e, sa0});
			if (nb == 0) tx = sh[0] && sel;
			else if (nb == 1 && sel) {inc, idx} = sh;
			else if (sel) begin
				mem[idx] = sh;
				idx = idx + inc;
				scl_hold = slow;
				scl_hold <= #3000 1'b0;
			end
			nb++;
			sda_en = sel;
		end else if (cnt == 0 && tx && sel) begin
			sh = mem[idx];
			idx = idx + inc;
			sent = 1'b1;
			sda_en = !sh[7];
		end else if (cnt != 8 && tx && sel) sda_en = !sh[7];
	end
	// SPI: capture on rising, launch on falling port clock
	always @(negedge cs) begin
		bc = 0;
		rw = 1'b0;
	end
	always @(posedge cs) begin
		sda_en = 1'b0;
		sda_val = 1'b0;
		sdo = !sdo;
	end
	always @(posedge scl) if (!cs) begin
		sh = {sh[6:0], sda};
		bc++;
		if (bc == 8) {rw, inc, idx} = {sh[7:6], 1'b0, sh[5:0]};
		else if (bc % 8 == 0 && !rw) begin
			mem[idx] = sh;
			idx = idx + inc;
		end
	end
	always @(negedge scl) if (!cs && rw && bc >= 8) begin
		if (bc % 8 == 0) begin
			dout = mem[idx];
			// fifo burst wraps back over the pressure outputs
			if (inc && idx == 7'h2a && mem[33][FIFO_BIT] === 1'b1)
				idx = 7'h28;
			else
				idx = idx + inc;
		end
		sdo = dout[7];
		sda_val = dout[7];
		sda_en = (mem[32][SIM_BIT] === 1'b1);
		dout = dout << 1;
	end
endmodule : sensor_model

// >>> tb/serial_port_host_bench.sv
// Purpose: self-checking bench for the serial register port host
// Assumes: sensor_model on the pads, address-select tied high
// Notes:   ctrl bits: spi 0, three-wire 1, read 2, inc 3, asel 4
module serial_port_host_bench
	import sensor_link_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys = 1'b0;
	logic       nrst = 1'b0;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       slow = 1'b0;
	logic       spi_on = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] st;
	logic       pc_drv, pc_en, dl_drv, dl_en, cs, hold, m_en, m_val, sdo_pin;
	wire        scl = pc_en ? pc_drv : !hold;
	wire        sda = dl_en ? dl_drv : (m_en ? m_val : 1'b1);
	int         failures = 0;
	int         checks_done = 0;
	int         cycles = 0;
	int         rises = 0;
	int         stray = 0;
	int         starts = 0;
	int         stops = 0;
	real        t_last = 0.0;
	real        gap_min = 1.0e9;
	serial_port_host serial_port_host_i (.clk_sys(clk_sys), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.port_clock_level(scl), .port_clock_drive(pc_drv),
		.port_clock_en(pc_en), .data_line_level(sda),
		.data_line_drive(dl_drv), .data_line_en(dl_en),
		.serial_out_addr_select_pin(sdo_pin), .chip_select(cs));
	sensor_model sensor_model_i (.scl(scl), .sda(sda), .cs(cs), .sa0(1'b1),
		.slow(slow), .scl_hold(hold), .sda_en(m_en), .sda_val(m_val),
		.sdo_pin(sdo_pin));
	initial begin
		forever #12.5 clk_sys = !clk_sys;
	end
	always @(posedge scl) begin
		if (cs === 1'b0) rises++;
		if (cs && $realtime - t_last < gap_min) gap_min = $realtime - t_last;
		t_last = $realtime;
	end
	always @(negedge scl) if (spi_on && cs) stray++;
	always @(negedge sda) if (scl === 1'b1 && cs === 1'b1) starts++;
	always @(posedge sda) if (scl === 1'b1 && cs === 1'b1) stops++;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			tally_and_finish;
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic go(input logic [7:0] c, input logic [6:0] ix,
		input logic [3:0] n);
		wr_reg(REG_CTRL, c);
		wr_reg(REG_INDEX, {1'b0, ix});
		wr_reg(REG_COUNT, {4'h0, n});
		{rises, stray, starts, stops} = '0;
		gap_min = 1.0e9;
		sensor_model_i.macks = 0;
		sensor_model_i.nmacks = 0;
		wr_reg(REG_GO, 8'h01);
	endtask : go
	task automatic wait_idle;
		st = 8'h01;
		for (int i = 0; i < 12000 && st[0] !== 1'b0; i++)
			rd_reg(REG_STATUS, st);
	endtask : wait_idle
	task automatic run(input logic [7:0] c, input logic [6:0] ix,
		input logic [3:0] n);
		go(c, ix, n);
		wait_idle;
	endtask : run
	task automatic fill(input logic [7:0] e0, e1);
		wr_reg(5'h10, e0);
		wr_reg(5'h11, e1);
	endtask : fill
	task automatic chk_buf(input string what, input logic [7:0] e0, e1);
		logic [7:0] v;
		rd_reg(5'h10, v);
		chk(what, v, e0);
		rd_reg(5'h11, v);
		chk(what, v, e1);
	endtask : chk_buf
	// ----
	// tests
	// ----
	task automatic t_reset;
		logic [7:0] v;
		for (int a = 0; a < 6; a++) if (a != 3) begin
			rd_reg(5'(a), v);
			chk("reset value", v, 8'h00);
		end
		chk("idle cs", 8'(cs), 8'h01);
		$display("test reset done");
	endtask : t_reset
	task automatic t_i2c;
		logic [7:0] v;
		fill(8'ha1, 8'hb2);
		slow = 1'b1;
		run(8'h18, 7'h08, 4'h1);
		slow = 1'b0;
		chk("write status", st, 8'h04);
		chk("write starts", 8'(starts), 8'h01);
		chk("write stops", 8'(stops), 8'h01);
		chk("byte 0", sensor_model_i.mem[8], 8'ha1);
		chk("byte 1", sensor_model_i.mem[9], 8'hb2);
		chk("bit rate", 8'(gap_min >= 2500.0), 8'h01);
		run(8'h1c, 7'h08, 4'h1);
		chk("read starts", 8'(starts), 8'h02);
		chk("read acks", 8'(sensor_model_i.macks), 8'h01);
		chk("read no ack", 8'(sensor_model_i.nmacks), 8'h01);
		chk_buf("read data", 8'ha1, 8'hb2);
		run(8'h14, 7'h09, 4'h1);
		chk_buf("fixed read", 8'hb2, 8'hb2);
		go(8'h08, 7'h0f, 4'h0);
		wr_reg(REG_INDEX, 8'h55);
		wait_idle;
		chk("nack status", st, 8'h06);
		chk("nack stops", 8'(stops), 8'h01);
		rd_reg(REG_INDEX, v);
		chk("index while busy", v, 8'h0f);
		$display("test two-wire done");
	endtask : t_i2c
	task automatic t_spi;
		logic [7:0] v;
		spi_on = 1'b1;
		fill(8'h5a, 8'ha5);
		run(8'h09, 7'h10, 4'h1);
		chk("pulses", 8'(rises), 8'h18);
		chk("parked", 8'(stray), 8'h00);
		chk("spi byte 0", sensor_model_i.mem[16], 8'h5a);
		chk("spi byte 1", sensor_model_i.mem[17], 8'ha5);
		run(8'h0d, 7'h10, 4'h1);
		chk_buf("spi read", 8'h5a, 8'ha5);
		run(8'h05, 7'h11, 4'h1);
		chk_buf("spi fixed read", 8'ha5, 8'ha5);
		fill(8'hc8, 8'hc9);
		wr_reg(5'h12, 8'hca);
		run(8'h09, 7'h28, 4'h2);
		fill(8'h01, 8'h00);
		run(8'h01, 7'h21, 4'h0);
		run(8'h0d, 7'h29, 4'h2);
		chk_buf("fifo wrap", 8'hc9, 8'hca);
		rd_reg(5'h12, v);
		chk("fifo wrap", v, 8'hc8);
		fill(8'h01, 8'h00);
		run(8'h01, 7'h20, 4'h0);
		chk("single pulses", 8'(rises), 8'h10);
		run(8'h0f, 7'h10, 4'h1);
		chk_buf("three wire read", 8'h5a, 8'ha5);
		spi_on = 1'b0;
		$display("test spi done");
	endtask : t_spi
	initial begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset;
		t_i2c;
		t_spi;
		tally_and_finish;
	end
endmodule : serial_port_host_bench
